// *** rtl/sfdp_basic_param_table.sv ***
// Discovery parameter table: pointer, streaming byte reads and status over a plain register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01: Byte 00h returns A5h, the identifier of this embedded parameter block.
// R02: Length byte reads B0h, 176 following bytes, for both densities.
// R03: First basic-parameter byte sits at discovery address 1090h and reads E7h.
// R04: First byte: top bits ones, status write mode 00b, big buffer, no 4 KB erase.
// R05: Byte 01h reads FFh: no uniform 4 KB erase opcode.
// R06: Byte 02h reads B2h on single rate: quad I/O, dual I/O, 3/4 byte addresses.
// R07: Bit 19 reports double data rate: clear single rate, set double rate.
// R08: Bytes 04h-07h hold density minus one; top byte 07h or 0Fh.
// R09: Byte 08h reads 48h: quad I/O mode and dummy cycle counts.
// R10: Byte 09h holds EBh, the quad I/O read opcode.
// R11: Bytes 0Ah and 0Bh read FFh: quad-output read unsupported.
// R12: Bytes 0Ch and 0Dh read FFh: dual-output read unsupported.
// R13: Byte 0Eh reads 88h: dual I/O mode and dummy cycle counts.
// R14: Byte 0Fh holds BBh, the dual I/O read opcode.
// R15: Byte 03h of the first dword is unused and reads FFh.
// R16: Host sets a start address, then each byte read advances it by one.
module sfdp_basic_param_table #(
	parameter bit IS_DDR = 1'b0,
	parameter bit IS_256M = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [sfdp_pkg::BUS_AW-1:0] bus_addr,
	input wire logic [sfdp_pkg::BUS_DW-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output var logic [sfdp_pkg::BUS_DW-1:0] bus_rdata
);
	import sfdp_pkg::*;

	// ------------------------------------------------------------
	// Decode and pointer
	// ------------------------------------------------------------
	logic [PTR_W-1:0] ptr;
	logic [PTR_W-1:0] next_ptr;
	logic [7:0] rom_q;
	logic [15:0] disc_addr;
	logic ptr_load;
	logic data_pop;

	// A write to the pointer sets the start address; a data read consumes one byte.
	assign ptr_load = bus_wr && (bus_addr == REG_PTR);
	assign data_pop = bus_rd && (bus_addr == REG_DATA);

	// The pointer wraps at its width; the host ends a burst simply by stopping.
	always_comb begin
		if (ptr_load) begin
			next_ptr = bus_wdata[PTR_W-1:0]; // R16
		end else if (data_pop) begin
			next_ptr = PTR_W'(ptr + 8'h01); // R16
		end else begin
			next_ptr = ptr;
		end
	end

	// Pointer register.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ptr <= PTR_RST;
		end else begin
			ptr <= next_ptr;
		end
	end

	// Discovery-space address of the byte under the pointer.
	assign disc_addr = 16'(DISC_BASE + {8'h00, ptr} - {8'h00, OFS_DW1_B0}); // R03

	// ------------------------------------------------------------
	// Byte store
	// ------------------------------------------------------------

	// The store is addressed by the next pointer so that its registered output always
	// matches the current pointer, even right after a load or a pop.
	sfdp_param_rom #(
		.IS_DDR(IS_DDR),
		.IS_256M(IS_256M)
	) u_rom (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.rom_addr(next_ptr),
		.rom_q(rom_q)
	);

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------

	// Read data stand only in the cycle after the strobe; unmapped register indexes read zero.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bus_rdata <= RDATA_RST;
		end else if (bus_rd) begin
			case (bus_addr)
				REG_PTR: bus_rdata <= {8'h00, ptr};
				REG_DATA: bus_rdata <= {8'h00, rom_q}; // R16
				REG_DISC_ADDR: bus_rdata <= disc_addr; // R03
				REG_VARIANT: bus_rdata <= 16'({IS_256M, IS_DDR}); // R07
				default: bus_rdata <= RDATA_RST;
			endcase
		end else begin
			bus_rdata <= RDATA_RST;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// Pop of a given offset: helper sequence used by the content checks.
	sequence pop_at(logic [PTR_W-1:0] ofs);
		bus_rd && (bus_addr == REG_DATA) && (ptr == ofs);
	endsequence

	AST_ID_BYTE: assert property (pop_at(OFS_ID) |=> bus_rdata == {8'h00, BYTE_ID}) // R01
		else $error("Identifier byte is wrong.");

	AST_LEN_BYTE: assert property (pop_at(OFS_LEN) |=> bus_rdata == {8'h00, BYTE_LEN}) // R02
		else $error("Length byte is wrong.");

	AST_DISC_BASE: assert property (
		bus_rd && (bus_addr == REG_DISC_ADDR) && (ptr == OFS_DW1_B0) |=> bus_rdata == DISC_BASE) // R03
		else $error("First basic byte is not at the discovery base address.");

	AST_FIRST_FIELDS: assert property (pop_at(OFS_DW1_B0) |=>
		(bus_rdata[7:5] == DW1_UNUSED_HI) && (bus_rdata[4:3] == DW1_WRSR_MODE)
		&& bus_rdata[2] && (bus_rdata[1:0] == DW1_NO_4K_ERASE)) // R04
		else $error("First basic byte fields are wrong.");

	AST_NO_4K_OPCODE: assert property (pop_at(OFS_DW1_B1) |=> bus_rdata == {8'h00, BYTE_FF}) // R05
		else $error("4 KB erase opcode byte is not all ones.");

	AST_READ_MODES: assert property (pop_at(OFS_DW1_B2) |=>
		bus_rdata[7] && !bus_rdata[6] && bus_rdata[5] && bus_rdata[4]
		&& (bus_rdata[2:1] == DW1_ADDR_BYTES) && !bus_rdata[0]) // R06
		else $error("Supported read modes byte is wrong.");

	AST_DDR_BIT: assert property (pop_at(OFS_DW1_B2) |=> bus_rdata[3] == IS_DDR) // R07
		else $error("Double data rate bit does not match the variant.");

	AST_DW1_TOP: assert property (pop_at(OFS_DW1_B3) |=> bus_rdata[7:0] == BYTE_FF) // R15
		else $error("Unused top byte of the first dword is not all ones.");

	// A burst of four pops over the density word returns FFh, FFh, FFh, then the top byte.
	AST_DENSITY: assert property (
		pop_at(OFS_DENS_B0) ##1 (data_pop && !ptr_load) [*3] |=>
		($past(bus_rdata, 3) == {8'h00, BYTE_FF}) && ($past(bus_rdata, 2) == {8'h00, BYTE_FF})
		&& ($past(bus_rdata, 1) == {8'h00, BYTE_FF})
		&& (bus_rdata[7:0] == (IS_256M ? BYTE_DENS_TOP_256 : BYTE_DENS_TOP_128))) // R08
		else $error("Density word is wrong.");

	AST_QIO_WAIT: assert property (pop_at(OFS_QIO_WAIT) |=>
		(bus_rdata[7:5] == QIO_MODE_CYC) && (bus_rdata[4:0] == QIO_DUMMY_CYC)) // R09
		else $error("Quad I/O cycle counts are wrong.");

	AST_QIO_OP: assert property (pop_at(OFS_QIO_OP) |=> bus_rdata[7:0] == QIO_OPCODE) // R10
		else $error("Quad I/O opcode is wrong.");

	AST_QOUT_NONE: assert property (pop_at(OFS_QOUT_WAIT) ##1 data_pop |=>
		($past(bus_rdata) == {8'h00, BYTE_FF}) && (bus_rdata == {8'h00, BYTE_FF})) // R11
		else $error("Quad output read is not reported unsupported.");

	AST_DOUT_NONE: assert property (pop_at(OFS_DOUT_WAIT) ##1 data_pop |=>
		($past(bus_rdata) == {8'h00, BYTE_FF}) && (bus_rdata == {8'h00, BYTE_FF})) // R12
		else $error("Dual output read is not reported unsupported.");

	AST_DIO_WAIT: assert property (pop_at(OFS_DIO_WAIT) |=>
		(bus_rdata[7:5] == DIO_MODE_CYC) && (bus_rdata[4:0] == DIO_DUMMY_CYC)) // R13
		else $error("Dual I/O cycle counts are wrong.");

	AST_DIO_OP: assert property (pop_at(OFS_DIO_OP) |=> bus_rdata[7:0] == DIO_OPCODE) // R14
		else $error("Dual I/O opcode is wrong.");

	AST_PTR_ADVANCE: assert property (data_pop |=> ptr == PTR_W'($past(ptr) + 8'h01)) // R16
		else $error("Pointer did not advance by one after a byte read.");

	AST_PTR_LOAD: assert property (ptr_load |=> ptr == $past(bus_wdata[PTR_W-1:0])) // R16
		else $error("Pointer did not take the written start address.");

	AST_PTR_HOLD: assert property (!ptr_load && !data_pop |=> $stable(ptr)) // R16
		else $error("Pointer moved without a load or a byte read.");

	AST_RDATA_IDLE: assert property (!bus_rd |=> bus_rdata == RDATA_RST)
		else $error("Read data stand outside the cycle after a read.");

	// Main scenarios.
	COV_LOAD_THEN_POP: cover property (ptr_load ##1 data_pop);
	COV_BURST_FOUR: cover property (data_pop [*4]);
	COV_READ_DISC: cover property (bus_rd && (bus_addr == REG_DISC_ADDR));
	COV_LAST_BYTE: cover property (pop_at(OFS_DIO_OP));

endmodule

`default_nettype wire

// *** rtl/sfdp_pkg.sv ***
// Constants shared by the discovery parameter table and its byte store.
package sfdp_pkg;

	// ------------------------------------------------------------
	// Register port layout
	// ------------------------------------------------------------
	localparam int BUS_AW = 4;
	localparam int BUS_DW = 16;
	localparam int PTR_W = 8;
	localparam logic [BUS_AW-1:0] REG_PTR = 4'h0;
	localparam logic [BUS_AW-1:0] REG_DATA = 4'h1;
	localparam logic [BUS_AW-1:0] REG_DISC_ADDR = 4'h2;
	localparam logic [BUS_AW-1:0] REG_VARIANT = 4'h3;
	localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
	localparam logic [BUS_DW-1:0] RDATA_RST = 16'h0000;
	localparam int VAR_DDR_BIT = 0;
	localparam int VAR_DENSITY_BIT = 1;

	// ------------------------------------------------------------
	// Parameter-relative byte offsets
	// ------------------------------------------------------------
	localparam logic [PTR_W-1:0] OFS_ID = 8'h00;
	localparam logic [PTR_W-1:0] OFS_LEN = 8'h01;
	localparam logic [PTR_W-1:0] OFS_DW1_B0 = 8'h02;
	localparam logic [PTR_W-1:0] OFS_DW1_B1 = 8'h03;
	localparam logic [PTR_W-1:0] OFS_DW1_B2 = 8'h04;
	localparam logic [PTR_W-1:0] OFS_DW1_B3 = 8'h05;
	localparam logic [PTR_W-1:0] OFS_DENS_B0 = 8'h06;
	localparam logic [PTR_W-1:0] OFS_DENS_B1 = 8'h07;
	localparam logic [PTR_W-1:0] OFS_DENS_B2 = 8'h08;
	localparam logic [PTR_W-1:0] OFS_DENS_B3 = 8'h09;
	localparam logic [PTR_W-1:0] OFS_QIO_WAIT = 8'h0a;
	localparam logic [PTR_W-1:0] OFS_QIO_OP = 8'h0b;
	localparam logic [PTR_W-1:0] OFS_QOUT_WAIT = 8'h0c;
	localparam logic [PTR_W-1:0] OFS_QOUT_OP = 8'h0d;
	localparam logic [PTR_W-1:0] OFS_DOUT_WAIT = 8'h0e;
	localparam logic [PTR_W-1:0] OFS_DOUT_OP = 8'h0f;
	localparam logic [PTR_W-1:0] OFS_DIO_WAIT = 8'h10;
	localparam logic [PTR_W-1:0] OFS_DIO_OP = 8'h11;

	// Discovery-space address of the first basic-parameter byte.
	localparam logic [15:0] DISC_BASE = 16'h1090;

	// ------------------------------------------------------------
	// Field values of the first dword
	// ------------------------------------------------------------
	localparam logic [2:0] DW1_UNUSED_HI = 3'b111;
	localparam logic [1:0] DW1_WRSR_MODE = 2'b00;
	localparam logic DW1_BIG_BUFFER = 1'b1;
	localparam logic [1:0] DW1_NO_4K_ERASE = 2'b11;
	localparam logic DW1_B2_UNUSED = 1'b1;
	localparam logic DW1_QUAD_OUT = 1'b0;
	localparam logic DW1_QUAD_IO = 1'b1;
	localparam logic DW1_DUAL_IO = 1'b1;
	localparam logic [1:0] DW1_ADDR_BYTES = 2'b01;
	localparam logic DW1_DUAL_OUT = 1'b0;

	// ------------------------------------------------------------
	// Table byte values
	// ------------------------------------------------------------
	localparam logic [7:0] BYTE_ID = 8'ha5;
	localparam logic [7:0] BYTE_LEN = 8'hb0;
	localparam logic [7:0] BYTE_FF = 8'hff;
	localparam logic [7:0] BYTE_DENS_TOP_128 = 8'h07;
	localparam logic [7:0] BYTE_DENS_TOP_256 = 8'h0f;
	localparam logic [2:0] QIO_MODE_CYC = 3'b010;
	localparam logic [4:0] QIO_DUMMY_CYC = 5'b01000;
	localparam logic [7:0] QIO_OPCODE = 8'heb;
	localparam logic [2:0] NONE_MODE_CYC = 3'b111;
	localparam logic [4:0] NONE_DUMMY_CYC = 5'b11111;
	localparam logic [2:0] DIO_MODE_CYC = 3'b100;
	localparam logic [4:0] DIO_DUMMY_CYC = 5'b01000;
	localparam logic [7:0] DIO_OPCODE = 8'hbb;

endpackage

// *** rtl/sfdp_param_rom.sv ***
// Constant byte store of the discovery parameter, read through a register.
`timescale 1ns/1ps
`default_nettype none

module sfdp_param_rom #(
	parameter bit IS_DDR = 1'b0,
	parameter bit IS_256M = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [sfdp_pkg::PTR_W-1:0] rom_addr,
	output var logic [7:0] rom_q
);
	import sfdp_pkg::*;

	// ------------------------------------------------------------
	// Byte lookup
	// ------------------------------------------------------------

	// Every byte is a constant; offsets past the table read as all ones.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rom_q <= BYTE_ID;
		end else begin
			case (rom_addr)
				OFS_ID: rom_q <= BYTE_ID; // R01
				OFS_LEN: rom_q <= BYTE_LEN; // R02
				OFS_DW1_B0: rom_q <= {DW1_UNUSED_HI, DW1_WRSR_MODE, DW1_BIG_BUFFER, DW1_NO_4K_ERASE}; // R04
				OFS_DW1_B1: rom_q <= BYTE_FF; // R05
				OFS_DW1_B2: rom_q <= {DW1_B2_UNUSED, DW1_QUAD_OUT, DW1_QUAD_IO, DW1_DUAL_IO,
					IS_DDR, DW1_ADDR_BYTES, DW1_DUAL_OUT}; // R06 R07
				OFS_DW1_B3: rom_q <= BYTE_FF; // R15
				OFS_DENS_B3: rom_q <= IS_256M ? BYTE_DENS_TOP_256 : BYTE_DENS_TOP_128; // R08
				OFS_QIO_WAIT: rom_q <= {QIO_MODE_CYC, QIO_DUMMY_CYC}; // R09
				OFS_QIO_OP: rom_q <= QIO_OPCODE; // R10
				OFS_QOUT_WAIT: rom_q <= {NONE_MODE_CYC, NONE_DUMMY_CYC}; // R11
				OFS_DOUT_WAIT: rom_q <= {NONE_MODE_CYC, NONE_DUMMY_CYC}; // R12
				OFS_DIO_WAIT: rom_q <= {DIO_MODE_CYC, DIO_DUMMY_CYC}; // R13
				OFS_DIO_OP: rom_q <= DIO_OPCODE; // R14
				default: rom_q <= BYTE_FF;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** verif/sfdp_host_model.sv ***
// Host-side bus master that walks the discovery table over the register port.
`timescale 1ns/1ps
`default_nettype none

module sfdp_host_model (
	input wire logic core_clk,
	output var logic [sfdp_pkg::BUS_AW-1:0] bus_addr,
	output var logic [sfdp_pkg::BUS_DW-1:0] bus_wdata,
	output var logic bus_wr,
	output var logic bus_rd,
	input wire logic [sfdp_pkg::BUS_DW-1:0] bus_rdata
);
	import sfdp_pkg::*;

	// The bus is quiet at time zero, so no strobe can land during reset.
	initial begin
		bus_addr = '0;
		bus_wdata = '0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end

	// -----------------------------------------------------------
	// Bus cycles
	// -----------------------------------------------------------

	// One write; idle lines then carry noise so stale values cannot pass for a match.
	task automatic wr_reg(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
		bus_addr <= BUS_AW'($urandom);
		bus_wdata <= BUS_DW'($urandom);
	endtask

	// Back-to-back reads of one index; returns n answers plus the idle cycle after them.
	task automatic rd_burst(input logic [BUS_AW-1:0] a, input int n, output logic [BUS_DW-1:0] q[$]);
		q = {};
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		for (int i = 0; i <= n + 1; i++) begin
			@(posedge core_clk);
			if (i > 0) begin
				q.push_back(bus_rdata);
			end
			if (i == n - 1) begin
				bus_rd <= 1'b0;
				bus_addr <= BUS_AW'($urandom);
			end
		end
	endtask
endmodule
`default_nettype wire

// *** verif/sfdp_basic_param_table_bench.sv ***
// Self-checking bench for the discovery parameter table, single-rate 128M and double-rate 256M builds.
`timescale 1ns/1ps
`default_nettype none

module sfdp_basic_param_table_bench;
	import sfdp_pkg::*;
	logic core_clk;
	logic sys_rst;
	logic [BUS_AW-1:0] addr0, addr1;
	logic [BUS_DW-1:0] wdata0, wdata1, rdata0, rdata1;
	logic wr0, wr1, rd0, rd1_s;
	int errors;
	int checked;
	int cycles;
	int ptr_m [2];
	logic [BUS_DW-1:0] q[$];

	// Free-running 40 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	sfdp_basic_param_table #(.IS_DDR(1'b0), .IS_256M(1'b0)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.bus_addr(addr0), .bus_wdata(wdata0), .bus_wr(wr0), .bus_rd(rd0), .bus_rdata(rdata0));
	sfdp_basic_param_table #(.IS_DDR(1'b1), .IS_256M(1'b1)) dut_alt (.core_clk(core_clk), .sys_rst(sys_rst),
		.bus_addr(addr1), .bus_wdata(wdata1), .bus_wr(wr1), .bus_rd(rd1_s), .bus_rdata(rdata1));
	sfdp_host_model host0 (.core_clk(core_clk), .bus_addr(addr0), .bus_wdata(wdata0), .bus_wr(wr0),
		.bus_rd(rd0), .bus_rdata(rdata0));
	sfdp_host_model host1 (.core_clk(core_clk), .bus_addr(addr1), .bus_wdata(wdata1), .bus_wr(wr1),
		.bus_rd(rd1_s), .bus_rdata(rdata1));

	// -----------------------------------------------------------
	// Reference model and helpers
	// -----------------------------------------------------------

	// Table byte at a pointer; variant 1 is the double-rate, larger part.
	function automatic logic [7:0] tbl(input int p, input int v);
		case (p)
			0: return 8'ha5;
			1: return 8'hb0;
			2: return 8'he7;
			4: return v ? 8'hba : 8'hb2;
			9: return v ? 8'h0f : 8'h07;
			10: return 8'h48;
			11: return 8'heb;
			16: return 8'h88;
			17: return 8'hbb;
			default: return 8'hff;
		endcase
	endfunction

	task automatic check(input logic [BUS_DW-1:0] seen, input logic [BUS_DW-1:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Writes to the pointer move the model; writes elsewhere must leave it alone.
	task automatic wr(input int v, input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
		if (v == 0) host0.wr_reg(a, d);
		else host1.wr_reg(a, d);
		if (a == REG_PTR) ptr_m[v] = d[7:0];
	endtask

	task automatic burst(input int v, input logic [BUS_AW-1:0] a, input int n);
		if (v == 0) host0.rd_burst(a, n, q);
		else host1.rd_burst(a, n, q);
	endtask

	// Single read; the answer stands one cycle and the bus returns to zero.
	task automatic rd1(input int v, input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] exp);
		burst(v, a, 1);
		check(q[0], exp);
		check(q[1], 16'h0000);
	endtask

	// Stream n bytes back to back and follow the pointer walk in the model.
	task automatic pop(input int v, input int n);
		burst(v, REG_DATA, n);
		for (int i = 0; i < n; i++) begin
			check(q[i], {8'h00, tbl((ptr_m[v] + i) % 256, v)});
		end
		check(q[n], 16'h0000);
		ptr_m[v] = (ptr_m[v] + n) % 256;
	endtask

	task automatic final_report();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// A hung handshake is cut short well past the expected run length.
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			final_report();
		end
	end

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		errors = 0;
		checked = 0;
		cycles = 0;
		ptr_m = '{0, 0};
		sys_rst = 1'b1;
		void'($urandom(32'hab5dc212));
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int v = 0; v < 2; v++) begin
			rd1(v, REG_PTR, 16'h0000);
			rd1(v, REG_DISC_ADDR, 16'h108e);
			rd1(v, REG_VARIANT, v ? 16'h0003 : 16'h0000);
			pop(v, 258);
			wr(v, REG_PTR, 16'h0002);
			rd1(v, REG_DISC_ADDR, 16'h1090);
			for (int k = 0; k < 30; k++) begin
				wr(v, REG_PTR, 16'($urandom));
				rd1(v, REG_PTR, {8'h00, 8'(ptr_m[v])});
				rd1(v, REG_DISC_ADDR, 16'(32'h108e + ptr_m[v]));
				wr(v, 4'(1 + $urandom_range(14)), 16'($urandom));
				rd1(v, 4'(4 + $urandom_range(11)), 16'h0000);
				pop(v, 1 + $urandom_range(7));
			end
		end
		final_report();
	end
endmodule
`default_nettype wire
